// *** rtl/dmc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dmc_consts.svh"

module dmc_top (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic power_down_n_i,
    input wire logic control_select_strap_i,
    input wire logic csn_i,
    input wire logic cclk_i,
    input wire logic cdti_i,
    input wire logic [2:0] pin_audio_format_sel_i,
    input wire logic [1:0] pin_tdm_format_i,
    input wire logic pin_short_delay_sel_i,
    input wire logic pin_slow_rolloff_sel_i,
    input wire logic pin_super_slow_rolloff_sel_i,
    input wire logic [1:0] pin_deemphasis_sel_i,
    input wire logic pin_output_invert_i,
    input wire logic pin_soft_mute_i,
    output logic cdto_o,
    output logic pin_mode_o,
    output dmc_pkg::dmc_conv_mode_t conv_mode_o,
    output logic soft_reset_n_o,
    output logic [2:0] audio_format_sel_o,
    output logic ext_filter_clock_sel_o,
    output logic dsd_clock_ratio_sel_o,
    output logic dsd_filter_sel_o,
    output logic short_delay_sel_o,
    output logic slow_rolloff_sel_o,
    output logic super_slow_rolloff_sel_o,
    output logic [1:0] deemphasis_sel_o,
    output logic dsd_path_sel_o,
    output logic dsd_input_pin_sel_o,
    output logic [1:0] tdm_format_o,
    output logic daisy_chain_en_o,
    output logic [7:0] attenuation_left_o,
    output logic [7:0] attenuation_right_o,
    output logic zero_detect_en_o,
    output logic zero_flag_polarity_o,
    output logic mono_en_o,
    output logic channel_data_sel_o,
    output logic output_invert_l_o,
    output logic output_invert_r_o,
    output logic dsd_fullscale_mute_en_o,
    output logic clock_sync_en_o,
    output logic soft_mute_o
);
    import dmc_pkg::*;

    localparam logic [`DMC_NUM_REGS-1:0][7:0] REG_RESET = {
        `DMC_RST_0B,
        `DMC_RST_0A,
        `DMC_RST_09,
        `DMC_RST_08,
        `DMC_RST_07,
        `DMC_RST_06,
        `DMC_RST_05,
        `DMC_RST_04,
        `DMC_RST_03,
        `DMC_RST_02,
        `DMC_RST_01,
        `DMC_RST_00
    };

    dmc_state_t s;
    dmc_state_t next_s;

    // the hole at 0x08 and anything past 0x0b hold no storage
    function automatic logic addr_mapped(input logic [4:0] addr);
        addr_mapped = (addr < 5'(`DMC_NUM_REGS)) && (addr != `DMC_ADDR_HOLE);
    endfunction : addr_mapped

    function automatic logic [7:0] reg_read(input logic [`DMC_NUM_REGS-1:0][7:0] regs,
                                           input logic [4:0] addr);
        reg_read = 8'h00;
        if (addr_mapped(addr)) begin
            reg_read = regs[addr[3:0]];
        end
    endfunction : reg_read

    // chip bits are decoded for both the read header and the write commit
    function automatic logic chip_match(input logic [1:0] chip);
        chip_match = (chip == `DMC_CHIP_ADDR);
    endfunction : chip_match

    // mode-limited settings read zero outside their own conversion mode
    function automatic logic gate_mode(input dmc_conv_mode_t cur,
                                       input dmc_conv_mode_t want,
                                       input logic value);
        gate_mode = (cur == want) && value;
    endfunction : gate_mode

    logic [7:0] r_mode;
    logic [7:0] r_filt;
    logic [7:0] r_dsdm;
    logic [7:0] r_invf;
    logic [7:0] r_dpth;
    logic [7:0] r_sync;
    logic [7:0] r_dflt;
    logic [7:0] r_tdm;
    logic [7:0] r_chn;
    logic [15:0] frame;
    logic [7:0] header;
    logic cclk_rise;
    logic cclk_fall;
    dmc_conv_mode_t reg_mode;
    logic read_hit;
    logic write_hit;
    logic [3:0] wr_index;

    assign r_mode = s.regs[`DMC_ADDR_MODE];
    assign r_filt = s.regs[`DMC_ADDR_FILT];
    assign r_dsdm = s.regs[`DMC_ADDR_DSDM];
    assign r_invf = s.regs[`DMC_ADDR_INVF];
    assign r_dpth = s.regs[`DMC_ADDR_DPTH];
    assign r_sync = s.regs[`DMC_ADDR_SYNC];
    assign r_dflt = s.regs[`DMC_ADDR_DFLT];
    assign r_tdm = s.regs[`DMC_ADDR_TDM];
    assign r_chn = s.regs[`DMC_ADDR_CHN];
    assign frame = {s.shift[14:0], cdti_i};
    assign header = frame[7:0];
    // cclk is slow against clock_i, so one-cycle edge pulses come from the last sample
    assign cclk_rise = cclk_i && !s.cclk_q;
    assign cclk_fall = !cclk_i && s.cclk_q;
    // header byte complete and it asks this chip for a read
    assign read_hit = (s.count == `DMC_HEADER_BITS - 5'h01) && !header[5] && chip_match(header[7:6]);
    // pin mode leaves the bank untouched; contents are ignored anyway
    assign write_hit = (s.count == `DMC_FRAME_BITS - 5'h01) && frame[13] && chip_match(frame[15:14])
        && addr_mapped(frame[12:8]) && !s.pin_mode;
    // only mapped addresses get written, so four index bits suffice
    assign wr_index = frame[11:8];

    always_comb begin
        // dsd bit overrides the external-filter bit
        if (r_dsdm[`DMC_B_DSD_MODE]) begin
            reg_mode = DMC_DSD;
        end else if (r_mode[`DMC_B_EXT_MODE]) begin
            reg_mode = DMC_EXT_FILTER_MODE_BIT;
        end else begin
            reg_mode = DMC_PCM;
        end
    end

    always_comb begin
        next_s = s;
        next_s.cclk_q = cclk_i;

        // serial control port, write-only frames plus a read-back path
        if (csn_i) begin
            next_s.count = 5'h00;
            next_s.rd_active = 1'b0;
            next_s.cdto = 1'b0;
        end else if (cclk_rise) begin
            next_s.shift = frame;
            if (s.count != `DMC_FRAME_BITS) begin
                next_s.count = s.count + 5'h01;
            end
            if (read_hit) begin
                next_s.rd_active = 1'b1;
                next_s.rd_data = reg_read(s.regs, header[4:0]);
            end
            if (write_hit) begin
                next_s.regs[wr_index] = frame[7:0];
            end
        end else if (cclk_fall && s.rd_active) begin
            next_s.cdto = s.rd_data[7];
            next_s.rd_data = {s.rd_data[6:0], 1'b0};
        end

        // strap is trusted while powered down and on the first cycle after reset; the host keeps it still otherwise
        if (!power_down_n_i || !s.strap_taken) begin
            next_s.pin_mode = control_select_strap_i;
            next_s.strap_taken = 1'b1;
        end
        // power-down reinitialises the whole bank
        if (!power_down_n_i) begin
            next_s.regs = REG_RESET;
            next_s.count = 5'h00;
            next_s.rd_active = 1'b0;
            next_s.cdto = 1'b0;
        end

        if (s.pin_mode) begin
            // registers carry no weight here, only the function pins
            next_s.conv_mode = DMC_PCM;
            next_s.soft_reset_n = 1'b1;
            next_s.audio_format = pin_audio_format_sel_i;
            next_s.ext_clk = 1'b0;
            next_s.dsd_clk = 1'b0;
            next_s.dsd_filt = 1'b0;
            next_s.short_delay = pin_short_delay_sel_i;
            next_s.slow = pin_slow_rolloff_sel_i;
            next_s.super_slow = pin_super_slow_rolloff_sel_i;
            next_s.deemph = pin_deemphasis_sel_i;
            next_s.dsd_path = 1'b0;
            next_s.dsd_pin = 1'b0;
            next_s.tdm = pin_tdm_format_i;
            next_s.daisy = 1'b0;
            next_s.att_l = `DMC_ATT_DEFAULT;
            next_s.att_r = `DMC_ATT_DEFAULT;
            next_s.zero_en = 1'b0;
            next_s.zero_pol = 1'b0;
            next_s.mono = 1'b0;
            next_s.chan_sel = 1'b0;
            next_s.inv_l = pin_output_invert_i;
            next_s.inv_r = pin_output_invert_i;
            next_s.fs_mute = 1'b0;
            next_s.sync_en = 1'b1;
            next_s.soft_mute = pin_soft_mute_i;
        end else begin
            // function pins are ignored from here down
            next_s.conv_mode = reg_mode;
            // mode changes are not blocked: sequencing them under soft reset is up to the host
            next_s.soft_reset_n = r_mode[`DMC_B_SOFT_RESET_N];
            // same code reads as msb-justified in pcm and lsb-justified in external mode
            next_s.audio_format = r_mode[`DMC_B_FMT_HI:`DMC_B_FMT_LO];
            next_s.ext_clk = gate_mode(reg_mode, DMC_EXT_FILTER_MODE_BIT, r_mode[`DMC_B_EXT_CLK]);
            next_s.dsd_clk = gate_mode(reg_mode, DMC_DSD, r_dsdm[`DMC_B_DSD_CLK]);
            next_s.dsd_filt = gate_mode(reg_mode, DMC_DSD, r_dflt[`DMC_B_DSD_FILT]);
            next_s.short_delay = gate_mode(reg_mode, DMC_PCM, r_filt[`DMC_B_SHORT_DELAY]);
            next_s.slow = gate_mode(reg_mode, DMC_PCM, r_dsdm[`DMC_B_SLOW]);
            next_s.super_slow = gate_mode(reg_mode, DMC_PCM, r_invf[`DMC_B_SUPER_SLOW]);
            if (reg_mode == DMC_PCM) begin
                next_s.deemph = r_filt[`DMC_B_DEEM_HI:`DMC_B_DEEM_LO];
                next_s.tdm = r_tdm[`DMC_B_TDM_HI:`DMC_B_TDM_LO];
            end else begin
                next_s.deemph = 2'h0;
                next_s.tdm = 2'h0;
            end
            next_s.daisy = (reg_mode == DMC_PCM) && r_chn[`DMC_B_CHAIN];
            next_s.dsd_path = (reg_mode == DMC_DSD) && r_dpth[`DMC_B_DSD_PATH];
            next_s.dsd_pin = r_dpth[`DMC_B_DSD_PIN];
            next_s.att_l = s.regs[`DMC_ADDR_ATTL];
            next_s.att_r = s.regs[`DMC_ADDR_ATTR];
            next_s.zero_en = r_filt[`DMC_B_ZERO_EN];
            next_s.zero_pol = r_dsdm[`DMC_B_ZERO_POL];
            next_s.mono = r_dsdm[`DMC_B_MONO];
            next_s.chan_sel = r_dsdm[`DMC_B_CHAN_SEL];
            next_s.inv_l = r_invf[`DMC_B_INV_L];
            next_s.inv_r = r_invf[`DMC_B_INV_R];
            next_s.fs_mute = (reg_mode == DMC_DSD) && r_dpth[`DMC_B_FS_MUTE];
            next_s.sync_en = (reg_mode != DMC_DSD) && r_sync[`DMC_B_SYNC_EN];
            next_s.soft_mute = r_filt[`DMC_B_SOFT_MUTE];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s.regs <= REG_RESET;
            s.strap_taken <= 1'b0;
            // pin control until the strap is first captured
            s.pin_mode <= 1'b1;
            s.cclk_q <= 1'b0;
            s.shift <= 16'h0000;
            s.count <= 5'h00;
            s.rd_active <= 1'b0;
            s.rd_data <= 8'h00;
            s.cdto <= 1'b0;
            s.conv_mode <= DMC_PCM;
            s.soft_reset_n <= 1'b0;
            s.audio_format <= `DMC_FMT_DEFAULT;
            s.ext_clk <= 1'b0;
            s.dsd_clk <= 1'b0;
            s.dsd_filt <= 1'b0;
            s.short_delay <= 1'b0;
            s.slow <= 1'b0;
            s.super_slow <= 1'b0;
            s.deemph <= 2'h0;
            s.dsd_path <= 1'b0;
            s.dsd_pin <= 1'b0;
            s.tdm <= 2'h0;
            s.daisy <= 1'b0;
            s.att_l <= `DMC_ATT_DEFAULT;
            s.att_r <= `DMC_ATT_DEFAULT;
            s.zero_en <= 1'b0;
            s.zero_pol <= 1'b0;
            s.mono <= 1'b0;
            s.chan_sel <= 1'b0;
            s.inv_l <= 1'b0;
            s.inv_r <= 1'b0;
            s.fs_mute <= 1'b0;
            s.sync_en <= 1'b1;
            s.soft_mute <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // every output is a straight copy of a state flop
    assign cdto_o = s.cdto;
    assign pin_mode_o = s.pin_mode;
    assign conv_mode_o = s.conv_mode;
    assign soft_reset_n_o = s.soft_reset_n;
    assign audio_format_sel_o = s.audio_format;
    assign ext_filter_clock_sel_o = s.ext_clk;
    assign dsd_clock_ratio_sel_o = s.dsd_clk;
    assign dsd_filter_sel_o = s.dsd_filt;
    assign short_delay_sel_o = s.short_delay;
    assign slow_rolloff_sel_o = s.slow;
    assign super_slow_rolloff_sel_o = s.super_slow;
    assign deemphasis_sel_o = s.deemph;
    assign dsd_path_sel_o = s.dsd_path;
    assign dsd_input_pin_sel_o = s.dsd_pin;
    assign tdm_format_o = s.tdm;
    assign daisy_chain_en_o = s.daisy;
    assign attenuation_left_o = s.att_l;
    assign attenuation_right_o = s.att_r;
    assign zero_detect_en_o = s.zero_en;
    assign zero_flag_polarity_o = s.zero_pol;
    assign mono_en_o = s.mono;
    assign channel_data_sel_o = s.chan_sel;
    assign output_invert_l_o = s.inv_l;
    assign output_invert_r_o = s.inv_r;
    assign dsd_fullscale_mute_en_o = s.fs_mute;
    assign clock_sync_en_o = s.sync_en;
    assign soft_mute_o = s.soft_mute;

endmodule : dmc_top

`default_nettype wire

// *** rtl/dmc_consts.svh ***
`ifndef DMC_CONSTS_SVH
`define DMC_CONSTS_SVH

// register offsets
`define DMC_ADDR_MODE 5'h00
`define DMC_ADDR_FILT 5'h01
`define DMC_ADDR_DSDM 5'h02
`define DMC_ADDR_ATTL 5'h03
`define DMC_ADDR_ATTR 5'h04
`define DMC_ADDR_INVF 5'h05
`define DMC_ADDR_DPTH 5'h06
`define DMC_ADDR_SYNC 5'h07
`define DMC_ADDR_HOLE 5'h08
`define DMC_ADDR_DFLT 5'h09
`define DMC_ADDR_TDM 5'h0A
`define DMC_ADDR_CHN 5'h0B
`define DMC_NUM_REGS 12

// field positions, mode_format_reset_ctrl (0x00)
`define DMC_B_SOFT_RESET_N 0
`define DMC_B_FMT_LO 1
`define DMC_B_FMT_HI 3
`define DMC_B_EXT_CLK 5
`define DMC_B_EXT_MODE 6
// filter_deemph_mute_ctrl (0x01)
`define DMC_B_SOFT_MUTE 0
`define DMC_B_DEEM_LO 1
`define DMC_B_DEEM_HI 2
`define DMC_B_SHORT_DELAY 5
`define DMC_B_ZERO_EN 7
// dsd_mono_zero_ctrl (0x02)
`define DMC_B_SLOW 0
`define DMC_B_CHAN_SEL 1
`define DMC_B_ZERO_POL 2
`define DMC_B_MONO 3
`define DMC_B_DSD_CLK 5
`define DMC_B_DSD_MODE 7
// invert_filter_ctrl (0x05)
`define DMC_B_SUPER_SLOW 0
`define DMC_B_INV_R 6
`define DMC_B_INV_L 7
// dsd_path_mute_ctrl (0x06)
`define DMC_B_DSD_PATH 1
`define DMC_B_FS_MUTE 2
`define DMC_B_DSD_PIN 7
// clock_sync_ctrl, dsd_filter_ctrl, tdm_format_ctrl, chain_ctrl
`define DMC_B_SYNC_EN 0
`define DMC_B_DSD_FILT 0
`define DMC_B_TDM_LO 6
`define DMC_B_TDM_HI 7
`define DMC_B_CHAIN 1

// reset values
`define DMC_RST_00 8'h0C
`define DMC_RST_01 8'h00
`define DMC_RST_02 8'h00
`define DMC_RST_03 8'hFF
`define DMC_RST_04 8'hFF
`define DMC_RST_05 8'h00
`define DMC_RST_06 8'h00
`define DMC_RST_07 8'h01
`define DMC_RST_08 8'h00
`define DMC_RST_09 8'h00
`define DMC_RST_0A 8'h00
`define DMC_RST_0B 8'h00
`define DMC_FMT_DEFAULT 3'h6
`define DMC_ATT_DEFAULT 8'hFF

// serial control frame: chip[1:0], write flag, address[4:0], data[7:0]
`define DMC_FRAME_BITS 5'h10
`define DMC_HEADER_BITS 5'h08
`define DMC_CHIP_ADDR 2'h0

`endif

// *** rtl/dmc_pkg.sv ***
`include "dmc_consts.svh"

package dmc_pkg;

    typedef enum logic [1:0] {
        DMC_PCM,
        DMC_DSD,
        DMC_EXT_FILTER_MODE_BIT
    } dmc_conv_mode_t;

    typedef struct packed {
        logic [`DMC_NUM_REGS-1:0][7:0] regs;
        logic strap_taken;
        logic pin_mode;
        logic cclk_q;
        logic [15:0] shift;
        logic [4:0] count;
        logic rd_active;
        logic [7:0] rd_data;
        logic cdto;
        dmc_conv_mode_t conv_mode;
        logic soft_reset_n;
        logic [2:0] audio_format;
        logic ext_clk;
        logic dsd_clk;
        logic dsd_filt;
        logic short_delay;
        logic slow;
        logic super_slow;
        logic [1:0] deemph;
        logic dsd_path;
        logic dsd_pin;
        logic [1:0] tdm;
        logic daisy;
        logic [7:0] att_l;
        logic [7:0] att_r;
        logic zero_en;
        logic zero_pol;
        logic mono;
        logic chan_sel;
        logic inv_l;
        logic inv_r;
        logic fs_mute;
        logic sync_en;
        logic soft_mute;
    } dmc_state_t;

endpackage : dmc_pkg

// *** tb/dmc_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

module dmc_top_assertions
    import dmc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic power_down_n_i,
    input wire logic control_select_strap_i,
    input wire logic csn_i,
    input wire logic [2:0] pin_audio_format_sel_i,
    input wire logic pin_output_invert_i,
    input wire logic pin_mode_o,
    input wire dmc_pkg::dmc_conv_mode_t conv_mode_o,
    input wire logic [2:0] audio_format_sel_o,
    input wire logic ext_filter_clock_sel_o,
    input wire logic dsd_clock_ratio_sel_o,
    input wire logic dsd_filter_sel_o,
    input wire logic [1:0] deemphasis_sel_o,
    input wire logic dsd_path_sel_o,
    input wire logic [1:0] tdm_format_o,
    input wire logic daisy_chain_en_o,
    input wire logic [7:0] attenuation_left_o,
    input wire logic zero_detect_en_o,
    input wire logic mono_en_o,
    input wire logic output_invert_l_o,
    input wire logic dsd_fullscale_mute_en_o,
    input wire logic clock_sync_en_o,
    input wire logic soft_mute_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // three edges of settled pins in pin control
    sequence s_pin_steady;
        (pin_mode_o && $stable(pin_audio_format_sel_i) && $stable(pin_output_invert_i))[*3];
    endsequence
    // register control with no frame and no power-down
    sequence s_reg_quiet;
        (!pin_mode_o && csn_i && power_down_n_i)[*3];
    endsequence

    strap_capture_a: assert property (!power_down_n_i |=> pin_mode_o == $past(control_select_strap_i))
        else $error("strap level not taken while powered down");
    pin_follow_a: assert property (s_pin_steady |-> audio_format_sel_o == pin_audio_format_sel_i && output_invert_l_o == pin_output_invert_i)
        else $error("pin settings not followed");
    pin_ignore_a: assert property (pin_mode_o && $past(pin_mode_o) |-> attenuation_left_o == 8'hFF && !zero_detect_en_o && !mono_en_o && clock_sync_en_o && conv_mode_o == DMC_PCM)
        else $error("register setting leaks into pin control");
    reg_ignore_a: assert property (s_reg_quiet |-> $stable(audio_format_sel_o) && $stable(output_invert_l_o) && $stable(soft_mute_o))
        else $error("pins disturb register control");
    pd_default_a: assert property (!power_down_n_i ##1 !power_down_n_i |=> attenuation_left_o == 8'hFF && !zero_detect_en_o && !mono_en_o && conv_mode_o == DMC_PCM && clock_sync_en_o)
        else $error("power-down defaults wrong");
    dsd_only_a: assert property (conv_mode_o != DMC_DSD |-> !dsd_clock_ratio_sel_o && !dsd_filter_sel_o && !dsd_path_sel_o && !dsd_fullscale_mute_en_o)
        else $error("dsd setting active outside dsd");
    ext_clock_a: assert property (conv_mode_o != DMC_EXT_FILTER_MODE_BIT |-> !ext_filter_clock_sel_o)
        else $error("external clock select outside its mode");
    pcm_only_a: assert property (conv_mode_o != DMC_PCM |-> deemphasis_sel_o == 2'h0 && tdm_format_o == 2'h0 && !daisy_chain_en_o)
        else $error("pcm setting active outside pcm");
    sync_dsd_a: assert property (conv_mode_o == DMC_DSD |-> !clock_sync_en_o)
        else $error("clock sync active in dsd");
endmodule : dmc_top_assertions

bind dmc_top dmc_top_assertions dmc_top_assertions_i (.clock_i(clock_i), .rst_i(rst_i),
    .power_down_n_i(power_down_n_i), .control_select_strap_i(control_select_strap_i), .csn_i(csn_i),
    .pin_audio_format_sel_i(pin_audio_format_sel_i), .pin_output_invert_i(pin_output_invert_i),
    .pin_mode_o(pin_mode_o), .conv_mode_o(conv_mode_o), .audio_format_sel_o(audio_format_sel_o),
    .ext_filter_clock_sel_o(ext_filter_clock_sel_o), .dsd_clock_ratio_sel_o(dsd_clock_ratio_sel_o),
    .dsd_filter_sel_o(dsd_filter_sel_o), .deemphasis_sel_o(deemphasis_sel_o), .dsd_path_sel_o(dsd_path_sel_o),
    .tdm_format_o(tdm_format_o), .daisy_chain_en_o(daisy_chain_en_o), .attenuation_left_o(attenuation_left_o),
    .zero_detect_en_o(zero_detect_en_o), .mono_en_o(mono_en_o), .output_invert_l_o(output_invert_l_o),
    .dsd_fullscale_mute_en_o(dsd_fullscale_mute_en_o), .clock_sync_en_o(clock_sync_en_o), .soft_mute_o(soft_mute_o));

`default_nettype wire

// *** tb/dmc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module dmc_host_model (
    input wire logic clock_i,
    input wire logic cdto_i,
    output logic csn_o,
    output logic cclk_o,
    output logic cdti_o
);
    // serial clock stands low between frames
    initial begin
        csn_o = 1'b1;
        cclk_o = 1'b0;
        cdti_o = 1'b0;
    end

    // each phase held three clocks, so the sampler always sees it
    task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge clock_i);
        csn_o = 1'b0;
        for (int k = 0; k < 16; k++) begin
            cdti_o = frame[15-k];
            repeat (3) @(negedge clock_i);
            if (k >= 8) rd[15-k] = cdto_i;
            cclk_o = 1'b1;
            repeat (3) @(negedge clock_i);
            cclk_o = 1'b0;
        end
        // released data line must not keep the last bit
        cdti_o = ~cdti_o;
        csn_o = 1'b1;
        repeat (2) @(negedge clock_i);
    endtask : xfer
endmodule : dmc_host_model

`default_nettype wire

// *** tb/dmc_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dmc_consts.svh"

module dmc_top_tb_top;
    import dmc_pkg::*;
    logic clock_i, rst_i, pdn, strap, csn, cclk, cdti, cdto, p_sd, p_slow, p_ss, p_inv, p_mute;
    logic [2:0] p_fmt, fmt;
    logic [1:0] p_tdm, p_dem, dem, tdm;
    dmc_conv_mode_t conv, md;
    logic pin_mode, srst_n, ext_filter_clock_sel, dsd_clock_ratio_sel, dflt, dpath, daisy_chain_en, zen, zpol, mono, csel, inv_l, inv_r, fsm, sync, smute;
    logic sd, slw, sslw, dpin;
    logic [7:0] att_l, att_r, v, d;
    logic [7:0] shadow [12];
    logic [7:0] rst_val [12] = '{`DMC_RST_00, `DMC_RST_01, `DMC_RST_02, `DMC_RST_03, `DMC_RST_04, `DMC_RST_05,
        `DMC_RST_06, `DMC_RST_07, `DMC_RST_08, `DMC_RST_09, `DMC_RST_0A, `DMC_RST_0B};
    logic [4:0] al [6] = '{5'h01, 5'h02, 5'h06, 5'h07, 5'h09, 5'h0A};
    logic [31:0] seed = 32'h0000_855d;
    int n_mismatch = 0;
    int n_tests = 0;

    dmc_host_model dmc_host_model_i (.clock_i(clock_i), .cdto_i(cdto), .csn_o(csn), .cclk_o(cclk), .cdti_o(cdti));

    dmc_top dmc_top_i (.clock_i(clock_i), .rst_i(rst_i), .power_down_n_i(pdn), .control_select_strap_i(strap),
        .csn_i(csn), .cclk_i(cclk), .cdti_i(cdti), .pin_audio_format_sel_i(p_fmt), .pin_tdm_format_i(p_tdm),
        .pin_short_delay_sel_i(p_sd), .pin_slow_rolloff_sel_i(p_slow), .pin_super_slow_rolloff_sel_i(p_ss),
        .pin_deemphasis_sel_i(p_dem), .pin_output_invert_i(p_inv), .pin_soft_mute_i(p_mute), .cdto_o(cdto),
        .pin_mode_o(pin_mode), .conv_mode_o(conv), .soft_reset_n_o(srst_n), .audio_format_sel_o(fmt),
        .ext_filter_clock_sel_o(ext_filter_clock_sel), .dsd_clock_ratio_sel_o(dsd_clock_ratio_sel), .dsd_filter_sel_o(dflt), .short_delay_sel_o(sd),
        .slow_rolloff_sel_o(slw), .super_slow_rolloff_sel_o(sslw), .deemphasis_sel_o(dem), .dsd_path_sel_o(dpath),
        .dsd_input_pin_sel_o(dpin), .tdm_format_o(tdm), .daisy_chain_en_o(daisy_chain_en), .attenuation_left_o(att_l),
        .attenuation_right_o(att_r), .zero_detect_en_o(zen), .zero_flag_polarity_o(zpol), .mono_en_o(mono),
        .channel_data_sel_o(csel), .output_invert_l_o(inv_l), .output_invert_r_o(inv_r),
        .dsd_fullscale_mute_en_o(fsm), .clock_sync_en_o(sync), .soft_mute_o(smute));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    function automatic dmc_conv_mode_t exp_mode(input logic [7:0] r0, input logic [7:0] r2);
        return r2[7] ? DMC_DSD : (r0[6] ? DMC_EXT_FILTER_MODE_BIT : DMC_PCM);
    endfunction : exp_mode

    task automatic rnd(output logic [7:0] r);
        seed = xs(seed);
        r = seed[7:0];
    endtask : rnd

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic b(input logic seen, input logic exp);
        check({7'h00, seen}, {7'h00, exp});
    endtask : b

    task automatic wr(input logic [4:0] a, input logic [7:0] dat);
        logic [7:0] junk;
        dmc_host_model_i.xfer({`DMC_CHIP_ADDR, 1'b1, a, dat}, junk);
    endtask : wr

    task automatic rdr(input logic [4:0] a, output logic [7:0] dat);
        dmc_host_model_i.xfer({`DMC_CHIP_ADDR, 1'b0, a, 8'h00}, dat);
    endtask : rdr

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clock_i);
        n_mismatch++;
        close_out();
    end

    initial begin
        {rst_i, pdn, strap, p_fmt, p_tdm, p_sd, p_slow, p_ss, p_dem, p_inv, p_mute} = 15'h6000;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        rst_i = 1'b0;
        repeat (3) @(negedge clock_i);
        for (int a = 0; a < 12; a++) begin
            rdr(a[4:0], v);
            check(v, rst_val[a]);
        end
        check(8'(fmt), 8'(`DMC_FMT_DEFAULT));
        check(8'(conv), 8'(DMC_PCM));
        // soft reset bit stays low while mode bits move
        for (int a = 0; a < 12; a++) begin
            rnd(d);
            if (a == 0) d[0] = 1'b0;
            wr(a[4:0], d);
            shadow[a] = (a == 8) ? 8'h00 : d;
            rdr(a[4:0], v);
            check(v, shadow[a]);
        end
        rdr(5'h1F, v);
        check(v, 8'h00);
        dmc_host_model_i.xfer({2'b01, 1'b1, 5'h07, ~shadow[7]}, v);
        rdr(5'h07, v);
        check(v, shadow[7]);
        for (int m = 0; m < 4; m++) begin
            rnd(d);
            d[6] = m[0];
            d[0] = 1'b0;
            wr(5'h00, d);
            shadow[0] = d;
            for (int j = 0; j < 6; j++) begin
                rnd(d);
                if (al[j] == 5'h02) d[7] = m[1];
                wr(al[j], d);
                shadow[al[j]] = d;
            end
            md = exp_mode(shadow[0], shadow[2]);
            check(8'(conv), 8'(md));
            b(dsd_clock_ratio_sel, md == DMC_DSD && shadow[2][5]);
            b(ext_filter_clock_sel, md == DMC_EXT_FILTER_MODE_BIT && shadow[0][5]);
            b(dflt, md == DMC_DSD && shadow[9][0]);
            check(8'(dem), (md == DMC_PCM) ? 8'(shadow[1][2:1]) : 8'h00);
            b(dpath, md == DMC_DSD && shadow[6][1]);
            if (md != DMC_DSD) check(8'(fmt), 8'(shadow[0][3:1]));
            check(8'(tdm), (md == DMC_PCM) ? 8'(shadow[10][7:6]) : 8'h00);
            check(8'({zen, zpol}), 8'({shadow[1][7], shadow[2][2]}));
            check(8'({mono, csel}), 8'({shadow[2][3], shadow[2][1]}));
            check(8'({inv_l, inv_r}), 8'({shadow[5][7], shadow[5][6]}));
            b(fsm, md == DMC_DSD && shadow[6][2]);
            b(sync, md != DMC_DSD && shadow[7][0]);
            b(sd, md == DMC_PCM && shadow[1][5]);
            b(slw, md == DMC_PCM && shadow[2][0]);
            b(sslw, md == DMC_PCM && shadow[5][0]);
            b(daisy_chain_en, md == DMC_PCM && shadow[11][1]);
            check(att_r, shadow[4]);
            b(dpin, shadow[6][7]);
            b(srst_n, 1'b0);
            repeat (8) @(negedge clock_i);
            wr(5'h00, shadow[0] | 8'h01);
            b(srst_n, 1'b1);
        end
        pdn = 1'b0;
        strap = 1'b1;
        repeat (3) @(negedge clock_i);
        pdn = 1'b1;
        for (int i = 0; i < 6; i++) begin
            rnd(d);
            {p_fmt, p_inv, p_dem, p_mute, p_sd} = d;
            rnd(d);
            {p_tdm, p_slow, p_ss} = d[3:0];
            wr(5'h03, d);
            b(pin_mode, 1'b1);
            check(8'({fmt, inv_l, inv_r, dem, smute}), 8'({p_fmt, p_inv, p_inv, p_dem, p_mute}));
            check(8'({tdm, sd, slw, sslw}), 8'({p_tdm, p_sd, p_slow, p_ss}));
            check(att_l, 8'hFF);
            rdr(5'h03, v);
            check(v, 8'hFF);
        end
        pdn = 1'b0;
        strap = 1'b0;
        repeat (3) @(negedge clock_i);
        pdn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rnd(d);
            {p_fmt, p_inv, p_dem, p_mute, p_sd} = d;
            repeat (4) @(negedge clock_i);
            b(pin_mode, 1'b0);
            check(8'({fmt, inv_l, smute}), 8'({`DMC_FMT_DEFAULT, 2'b00}));
        end
        rdr(5'h03, v);
        check(v, `DMC_ATT_DEFAULT);
        close_out();
    end
endmodule : dmc_top_tb_top

`default_nettype wire
